//--- hdl/short_transport_test_checker.sv
// Short transport layer test pattern checker with its configuration registers.
// Assumes lane words arrive already aligned and synchronous to REF_CLK.
`timescale 1ns/1ps
`include "stpl_regs.svh"
module short_transport_test_checker #(
   parameter int LANES = 8,
   parameter int WORD_W = 16
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [LANES-1:0] LANE_VALID,
   input wire logic [LANES*WORD_W-1:0] LANE_DATA,
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [`STPL_ADDR_W-1:0] CFG_ADDR,
   input wire logic [15:0] CFG_WDATA,
   output logic [15:0] CFG_RDATA,
   output logic CFG_RVALID,
   output logic SHORT_TEST_ALARM
);
   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   // Mask and status fields hold no more than eight lanes at bit 8 upward
   if (LANES < 1 || LANES > `STPL_MAX_LANES) begin : gen_bad_lanes
      $error("LANES must lie between 1 and 8");
   end
   if (WORD_W < 1) begin : gen_bad_width
      $error("WORD_W must be positive");
   end

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   stpl_pkg::reg16_t enable_q;
   stpl_pkg::reg16_t mask_q;
   logic [LANES-1:0] status_q;
   logic [LANES-1:0] status_d;
   logic [LANES-1:0] lane_err;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic alarm_q;
   wire logic sel_enable;
   wire logic sel_mask;
   wire logic sel_status;
   wire logic chk_on;
   wire logic [LANES-1:0] lane_mask;
   wire logic [LANES-1:0] clr_bits;
   wire logic [15:0] status_word;
   wire logic [15:0] rd_mux;

   assign sel_enable = (CFG_ADDR == `STPL_OFS_ENABLE);
   assign sel_mask = (CFG_ADDR == `STPL_OFS_MASK);
   assign sel_status = (CFG_ADDR == `STPL_OFS_STATUS);
   assign chk_on = enable_q[`STPL_ENABLE_BIT];
   assign lane_mask = mask_q[`STPL_LANE_LSB +: LANES];
   // Write one to clear, so a read-modify-write cannot wipe fresh errors
   assign clr_bits = (CFG_WR && sel_status) ? CFG_WDATA[`STPL_LANE_LSB +: LANES] : '0;
   // Status placed at bits 8 upward
   assign status_word = 16'(status_q) << `STPL_LANE_LSB;
   // Unmapped offsets read as zero
   assign rd_mux = sel_enable ? enable_q :
                   sel_mask ? mask_q :
                   sel_status ? status_word : 16'h0000;
   assign status_d = (status_q & ~clr_bits) | lane_err;

   assign CFG_RDATA = rdata_q;
   assign CFG_RVALID = rvalid_q;
   assign SHORT_TEST_ALARM = alarm_q;

   // ----------------------------------------
   // Lane comparators
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : gen_lane
         lane_chk_if #(.W(WORD_W)) chk ();
         assign chk.en = chk_on;
         assign chk.valid = LANE_VALID[g];
         assign chk.data = LANE_DATA[g*WORD_W +: WORD_W];
         assign lane_err[g] = chk.mismatch;
         lane_pattern_check #(.W(WORD_W)) u_lane (
            .clk(REF_CLK),
            .rst_n(RST_N),
            .ce(CE),
            .chk(chk)
         );
      end
   endgenerate

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         enable_q <= `STPL_RST_ENABLE;
         mask_q <= `STPL_RST_MASK;
      end else if (CE && CFG_WR) begin
         if (sel_enable) begin
            enable_q <= CFG_WDATA;
         end
         if (sel_mask) begin
            mask_q <= CFG_WDATA;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         status_q <= '0;
         rdata_q <= `STPL_RST_STATUS;
         rvalid_q <= 1'b0;
         alarm_q <= 1'b0;
      end else if (CE) begin
         status_q <= status_d;
         rdata_q <= CFG_RD ? rd_mux : rdata_q;
         rvalid_q <= CFG_RD;
         alarm_q <= |(status_q & ~lane_mask);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_lane_error(int i);
      CE && lane_err[i];
   endsequence

   sequence s_lane_cleared(int i);
      CE && clr_bits[i];
   endsequence

   sequence s_lane_exposed(int i);
      CE && status_q[i] && !lane_mask[i];
   endsequence

   a_status_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && status_q[0] && !clr_bits[0]) |=> status_q[0])
      else $error("Lane 0 status dropped without a clear");

   a_set_beats_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (s_lane_error(0) and s_lane_cleared(0)) |=> status_q[0])
      else $error("Lane 0 error lost in the clearing cycle");

   a_clear_drops: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (s_lane_cleared(0) and (CE && !lane_err[0])) |=> !status_q[0])
      else $error("Lane 0 status survived a clear");

   a_error_reported: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      s_lane_error(LANES-1) |=> status_q[LANES-1])
      else $error("Top lane error missing from status");

   a_low_lane_reported: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      s_lane_error(0) |=> status_q[0])
      else $error("Lane 0 error missing from status");

   a_status_no_ghost: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && !status_q[0] && !lane_err[0]) |=> !status_q[0])
      else $error("Lane 0 status set without an error");

   a_status_readback: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && CFG_RD && sel_status) |=> (CFG_RVALID && CFG_RDATA[`STPL_LANE_LSB +: LANES] == $past(status_q)
         && CFG_RDATA[`STPL_LANE_LSB-1:0] == '0))
      else $error("Status read does not show lane bits at 8 upward");

   a_read_answer: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && CFG_RD) |=> CFG_RVALID)
      else $error("Read strobe got no valid answer");

   a_no_stray_answer: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && !CFG_RD) |=> !CFG_RVALID)
      else $error("Read valid without a read strobe");

   a_unmapped_read: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && CFG_RD && !(sel_enable || sel_mask || sel_status)) |=> CFG_RDATA == 16'h0000)
      else $error("Unmapped offset returned nonzero data");

   a_alarm_unmasked: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      s_lane_exposed(0) |=> SHORT_TEST_ALARM)
      else $error("Unmasked lane 0 error raised no alarm");

   a_alarm_masked: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && (status_q & ~lane_mask) == '0) |=> !SHORT_TEST_ALARM)
      else $error("Alarm raised with every erring lane masked");

   a_mask_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && CFG_WR && sel_mask) |=> mask_q == $past(CFG_WDATA))
      else $error("Mask register not taken from write");

   a_disabled_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && !chk_on) ##1 (CE && !chk_on) |-> lane_err == '0)
      else $error("Lane error while checker disabled");

   a_enable_write: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (CE && CFG_WR && sel_enable) |=> chk_on == $past(CFG_WDATA[`STPL_ENABLE_BIT]))
      else $error("Enable bit 12 not taken from write");

   a_freeze_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !CE |=> ($stable(status_q) && $stable(enable_q) && $stable(mask_q) && $stable(CFG_RDATA)
         && $stable(SHORT_TEST_ALARM)))
      else $error("State moved while clock enable low");
endmodule

//--- inc/stpl_regs.svh
// Register offsets, field positions and reset values of the short transport test checker.
// Assumes inclusion by bare name from package and design files.
`ifndef STPL_REGS_SVH
`define STPL_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define STPL_ADDR_W 7
`define STPL_OFS_ENABLE 7'h02
`define STPL_OFS_MASK 7'h06
`define STPL_OFS_STATUS 7'h6D

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define STPL_ENABLE_BIT 12
`define STPL_LANE_LSB 8
`define STPL_MAX_LANES 8
`define STPL_RST_ENABLE 16'h0000
`define STPL_RST_MASK 16'hFF00
`define STPL_RST_STATUS 16'h0000

`endif

//--- inc/stpl_pkg.sv
// Types shared by the short transport test checker files.
// Assumes stpl_regs.svh is on the include path.
package stpl_pkg;
   typedef logic [15:0] reg16_t;
   typedef enum logic [1:0] {
      CHK_IDLE,
      CHK_LEARN,
      CHK_COMPARE
   } chk_state_t;
endpackage

//--- inc/lane_chk_if.sv
// Signals between the top module and one lane comparator.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
interface lane_chk_if #(
   parameter int W = 16
);
   logic en;
   logic valid;
   logic [W-1:0] data;
   logic mismatch;
   modport top (output en, output valid, output data, input mismatch);
   modport lane (input en, input valid, input data, output mismatch);
endinterface

//--- hdl/lane_pattern_check.sv
// One lane comparator: learns the repeating test word, then flags any word that differs.
// Assumes the test pattern repeats every received word once the transmitter sends it.
`timescale 1ns/1ps
module lane_pattern_check #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   lane_chk_if.lane chk
);
   stpl_pkg::chk_state_t state_q;
   stpl_pkg::chk_state_t state_d;
   logic [W-1:0] ref_q;
   logic mismatch_q;
   wire logic differs;

   assign differs = chk.valid && (chk.data != ref_q);
   assign chk.mismatch = mismatch_q;

   // ----------------------------------------
   // State sequencing
   // ----------------------------------------
   always_comb begin
      case (state_q)
         stpl_pkg::CHK_IDLE: state_d = chk.en ? stpl_pkg::CHK_LEARN : stpl_pkg::CHK_IDLE;
         stpl_pkg::CHK_LEARN: state_d = !chk.en ? stpl_pkg::CHK_IDLE :
            (chk.valid ? stpl_pkg::CHK_COMPARE : stpl_pkg::CHK_LEARN);
         stpl_pkg::CHK_COMPARE: state_d = chk.en ? stpl_pkg::CHK_COMPARE : stpl_pkg::CHK_IDLE;
         default: state_d = stpl_pkg::CHK_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= stpl_pkg::CHK_IDLE;
         ref_q <= '0;
         mismatch_q <= 1'b0;
      end else if (ce) begin
         state_q <= state_d;
         if (state_q == stpl_pkg::CHK_LEARN && chk.valid) begin
            ref_q <= chk.data;
         end
         mismatch_q <= (state_q == stpl_pkg::CHK_COMPARE) && chk.en && differs;
      end
   end

   a_lane_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (ce && !chk.en) |=> !mismatch_q)
      else $error("Lane flagged mismatch while checker disabled");
endmodule

//--- dv/stpl_tx_model.sv
// Transmitter model: one repeating test word per lane.
// Assumes the bench drives run and err away from the rising edge.
`timescale 1ns/1ps
module stpl_tx_model #(
   parameter int LANES = 8,
   parameter int WORD_W = 16
) (
   input wire logic clk,
   input wire logic run,
   input wire logic [LANES-1:0] err,
   output logic [LANES-1:0] valid,
   output logic [LANES*WORD_W-1:0] data
);
   initial begin
      valid = '0;
      data = '0;
   end
   // matching pattern sent
   // Idle lines toggle so a stale word never looks valid
   always @(negedge clk) begin
      valid <= {LANES{run}};
      for (int g = 0; g < LANES; g++) begin
         data[g*WORD_W +: WORD_W] <= run ? WORD_W'(16'hA5C3 + g) ^ {WORD_W{err[g]}} : ~data[g*WORD_W +: WORD_W];
      end
   end
endmodule

//--- dv/test_short_transport_test_checker.sv
// Self-checking bench for the short transport test checker.
// Assumes the transmitter model in stpl_tx_model.sv.
`timescale 1ns/1ps
module test_short_transport_test_checker;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic run = 1'b0;
   logic [7:0] err = 8'h00;
   logic [7:0] valid;
   logic [127:0] data;
   logic wr = 1'b0;
   logic rd_s = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic rvalid;
   logic alarm;
   int bad_count = 0;
   int samples_checked = 0;

   initial begin
      forever #5 clk = ~clk;
   end

   short_transport_test_checker i_short_transport_test_checker (.REF_CLK(clk), .RST_N(rst_n), .CE(ce),
      .LANE_VALID(valid), .LANE_DATA(data), .CFG_WR(wr), .CFG_RD(rd_s), .CFG_ADDR(addr), .CFG_WDATA(wdata),
      .CFG_RDATA(rdata), .CFG_RVALID(rvalid), .SHORT_TEST_ALARM(alarm));
   stpl_tx_model i_stpl_tx_model (.clk(clk), .run(run), .err(err), .valid(valid), .data(data));

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [6:0] a, input logic [15:0] exp);
      int n;
      n = 0;
      @(negedge clk);
      rd_s = 1'b1;
      addr = a;
      @(negedge clk);
      rd_s = 1'b0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (n == 4) begin
         $display("ERROR read_valid expected 1 seen %b", rvalid);
         bad_count++;
         close_out();
      end else begin
         chk("read_data", exp, rdata);
      end
   endtask

   // One-cycle word error; non-blocking so the model reads it a full edge later
   task automatic hit(input logic [7:0] lanes);
      @(negedge clk);
      err <= lanes;
      @(negedge clk);
      err <= 8'h00;
      repeat (4) @(negedge clk);
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      rd_reg(7'h02, 16'h0000);
      rd_reg(7'h06, 16'hFF00);
      rd_reg(7'h6D, 16'h0000);
      rd_reg(7'h11, 16'h0000);
      $display("test reset_values done");
      run <= 1'b1;
      hit(8'h08);
      rd_reg(7'h6D, 16'h0000);
      $display("test disabled done");
      wr_reg(7'h02, 16'h1000);
      repeat (4) @(negedge clk);
      hit(8'h80);
      rd_reg(7'h6D, 16'h8000);
      chk("alarm_masked", 16'h0000, {15'h0000, alarm});
      wr_reg(7'h06, 16'hFE00);
      repeat (3) @(negedge clk);
      chk("alarm_lane0_open", 16'h0000, {15'h0000, alarm});
      wr_reg(7'h06, 16'h7F00);
      repeat (3) @(negedge clk);
      chk("alarm_lane7_open", 16'h0001, {15'h0000, alarm});
      rd_reg(7'h06, 16'h7F00);
      $display("test mask done");
      hit(8'h01);
      rd_reg(7'h6D, 16'h8100);
      wr_reg(7'h06, 16'hFE00);
      repeat (3) @(negedge clk);
      chk("alarm_lane0_err", 16'h0001, {15'h0000, alarm});
      wr_reg(7'h6D, 16'hFF00);
      repeat (3) @(negedge clk);
      rd_reg(7'h6D, 16'h0000);
      chk("alarm_cleared", 16'h0000, {15'h0000, alarm});
      $display("test sticky_clear done");
      ce = 1'b0;
      wr_reg(7'h02, 16'h0000);
      hit(8'h04);
      ce = 1'b1;
      rd_reg(7'h02, 16'h1000);
      rd_reg(7'h6D, 16'h0000);
      $display("test freeze done");
      // Error word reaches the lane so that its flag meets the clear strobe
      @(negedge clk);
      err <= 8'h01;
      @(negedge clk);
      err <= 8'h00;
      wr_reg(7'h6D, 16'h0100);
      rd_reg(7'h6D, 16'h0100);
      $display("test set_wins done");
      wr_reg(7'h02, 16'h0000);
      hit(8'h02);
      rd_reg(7'h6D, 16'h0100);
      $display("test disable_again done");
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      rd_reg(7'h6D, 16'h0000);
      rd_reg(7'h06, 16'hFF00);
      rd_reg(7'h02, 16'h0000);
      chk("alarm_reset", 16'h0000, {15'h0000, alarm});
      $display("test mid_reset done");
      close_out();
   end
endmodule
